// file: sram_lane_pkg.sv
// Purpose: Shared constants, lane modes and lane helpers for the serial SRAM link.
// Assumes: Both ends run on one fast system clock; the serial clock is a sampled pin.
// Notes:   Lane 3 doubles as the pause pin outside four-lane mode.
package sram_lane_pkg;

  typedef enum logic [1:0] {
    single_lane_mode = 2'b00,
    two_lane_mode    = 2'b01,
    four_lane_mode   = 2'b10
  } lane_mode_t;

  localparam logic [7:0] ENTER_TWO_LANE_CMD   = 8'h3B;
  localparam logic [7:0] ENTER_FOUR_LANE_CMD  = 8'h38;
  localparam logic [7:0] LANE_WIDTH_RESET_CMD = 8'hFF;

  localparam logic [3:0] BYTE_BITS      = 4'h8;
  localparam logic [3:0] CNT_ZERO       = 4'h0;
  localparam logic [3:0] MASK_SINGLE_IN = 4'h1;
  localparam logic [3:0] MASK_SINGLE_SO = 4'h2;
  localparam logic [3:0] MASK_TWO       = 4'h3;
  localparam logic [3:0] MASK_FOUR      = 4'hF;
  localparam logic [3:0] LANES_IDLE     = 4'hF;
  // Host serial clock half period in system clocks
  localparam logic [3:0] SCK_HALF_CYCLES = 4'h8;

  // Bits carried per serial clock
  function automatic logic [3:0] lane_step(lane_mode_t m);
    unique case (m)
      two_lane_mode:  lane_step = 4'h2;
      four_lane_mode: lane_step = 4'h4;
      default:        lane_step = 4'h1;
    endcase
  endfunction

  // Byte shifted left by one lane group, new bits entering at the bottom
  function automatic logic [7:0] shift_in(logic [7:0] sh, logic [3:0] b, lane_mode_t m);
    unique case (m)
      two_lane_mode:  shift_in = {sh[5:0], b[1:0]};
      four_lane_mode: shift_in = {sh[3:0], b};
      default:        shift_in = {sh[6:0], b[0]};
    endcase
  endfunction

  // Most significant group of a byte placed on the low lanes
  function automatic logic [3:0] lane_top(logic [7:0] sh, lane_mode_t m);
    unique case (m)
      two_lane_mode:  lane_top = {2'h0, sh[7:6]};
      four_lane_mode: lane_top = sh[7:4];
      default:        lane_top = {3'h0, sh[7]};
    endcase
  endfunction

endpackage

// file: sram_lane_if.sv
// Purpose: Wires between the SRAM serial front end and its bus master.
// Assumes: Each lane has a weak pull-up when nobody drives it.
// Notes:   Host drive wins a lane conflict; the checker flags such clashes.
`timescale 1ns/1ns
interface sram_lane_if;
  logic       cs_n;
  logic       sck;
  logic [3:0] host_out;
  logic [3:0] host_oe_n;
  logic [3:0] dev_out;
  logic [3:0] dev_oe_n;
  logic [3:0] lane;

  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign lane[i] = !host_oe_n[i] ? host_out[i] : (!dev_oe_n[i] ? dev_out[i] : 1'b1);
  end

  modport host (output cs_n, output sck, output host_out, output host_oe_n, input lane);
  modport device (input cs_n, input sck, input lane, output dev_out, output dev_oe_n);
endinterface

// file: sram_lane_host.sv
// Purpose: Bus master end: makes the serial clock, sends and reads bytes.
// Assumes: One request is taken while ready is high.
// Notes:   After reset it sends two lane-width resets to reach single-lane mode.
`timescale 1ns/1ns
module sram_lane_host
  import sram_lane_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  input  wire logic                      ce,
  // Link
  sram_lane_if.host                      link,
  // Byte requests
  input  wire logic                      req,
  input  wire logic [7:0]                req_data,
  input  wire logic                      req_read,
  input  wire logic                      req_last,
  input  wire logic                      pause_req,
  output logic                           ready,
  output logic                           ack,
  output logic [7:0]                     rsp_data,
  output sram_lane_pkg::lane_mode_t      lane_mode
);
  typedef enum logic [2:0] {
    h_idle  = 3'b000,
    h_low   = 3'b001,
    h_high  = 3'b010,
    h_wait  = 3'b011,
    h_stop  = 3'b100
  } host_state_t;

  host_state_t st_q, st_d;
  lane_mode_t  mode_q, mode_d;
  logic [3:0]  s1_q, s2_q, div_q, div_d, cnt_q, cnt_d, out_q, out_d, oe_n_q, oe_n_d;
  logic [7:0]  sh_q, sh_d, rsp_q, rsp_d;
  logic [1:0]  init_q, init_d;
  logic        read_q, read_d, last_q, last_d, first_q, first_d, int_q, int_d;
  logic        sck_q, sck_d, cs_n_q, cs_n_d, ack_q, ack_d, ready_q, ready_d;
  logic        half_done, hold_ok, take;
  logic [7:0]  rot;

  always_comb begin
    st_d = st_q; mode_d = mode_q; div_d = div_q; cnt_d = cnt_q; sh_d = sh_q;
    rsp_d = rsp_q; init_d = init_q; read_d = read_q; last_d = last_q;
    first_d = first_q; int_d = int_q; sck_d = sck_q; cs_n_d = cs_n_q;
    ack_d = 1'b0;
    half_done = (div_q == SCK_HALF_CYCLES - 4'h1);
    hold_ok = !(pause_req && mode_q != four_lane_mode);
    take = ready_q && req;
    // Written byte rotates by one lane group, so it is whole again after the last group
    rot = shift_in(sh_q, lane_top(sh_q, mode_q), mode_q);
    unique case (st_q)
      h_idle: begin
        if (init_q != 2'h0) begin
          // Device lane width unknown after our reset; four-lane try, then two-lane
          mode_d = (init_q == 2'h2) ? four_lane_mode : two_lane_mode;
          sh_d = LANE_WIDTH_RESET_CMD;
          read_d = 1'b0; last_d = 1'b1; int_d = 1'b1;
          cs_n_d = 1'b0; st_d = h_low; div_d = CNT_ZERO;
        end else if (take) begin
          sh_d = req_data; read_d = req_read; last_d = req_last; int_d = 1'b0;
          cs_n_d = 1'b0; st_d = h_low; div_d = CNT_ZERO;
        end
      end
      h_low: begin
        if (hold_ok) begin
          // Pause only while the clock is low, and cs stays low meanwhile
          div_d = div_q + 4'h1;
          if (half_done) begin
            if (read_q) sh_d = shift_in(sh_q, (mode_q == single_lane_mode) ?
                                       {3'h0, s2_q[1]} : s2_q, mode_q);
            cnt_d = cnt_q + lane_step(mode_q);
            sck_d = 1'b1; div_d = CNT_ZERO; st_d = h_high;
          end
        end else begin
          // Full low phase after a pause, so a release never meets a rising clock
          div_d = CNT_ZERO;
        end
      end
      h_high: begin
        div_d = div_q + 4'h1;
        if (half_done) begin
          sck_d = 1'b0; div_d = CNT_ZERO;
          if (cnt_q == BYTE_BITS) begin
            cnt_d = CNT_ZERO; first_d = 1'b0; ack_d = !int_q;
            rsp_d = read_q ? sh_q : rot;
            if (!read_q && first_q && !int_q) begin
              if (rot == ENTER_TWO_LANE_CMD) mode_d = two_lane_mode;
              else if (rot == ENTER_FOUR_LANE_CMD) mode_d = four_lane_mode;
              else if (rot == LANE_WIDTH_RESET_CMD) mode_d = single_lane_mode;
            end
            st_d = last_q ? h_stop : h_wait;
          end else begin
            if (!read_q) sh_d = rot;
            st_d = h_low;
          end
        end
      end
      h_wait: begin
        if (take) begin
          sh_d = req_data; read_d = req_read; last_d = req_last; st_d = h_low;
        end
      end
      h_stop: begin
        div_d = div_q + 4'h1;
        if (half_done) begin
          cs_n_d = 1'b1; first_d = 1'b1; st_d = h_idle; div_d = CNT_ZERO;
          if (int_q) begin
            init_d = init_q - 2'h1;
            if (init_q == 2'h1) mode_d = single_lane_mode;
          end
        end
      end
      default: st_d = h_idle;
    endcase
    ready_d = (st_d == h_idle && init_d == 2'h0) || (st_d == h_wait && !take);
    // Lane drive: data lanes only when writing; lane 3 holds the pause level outside four-lane mode
    out_d = lane_top(sh_d, mode_d);
    oe_n_d = LANES_IDLE;
    if (!cs_n_d && !read_d && st_d != h_stop) begin
      unique case (mode_d)
        two_lane_mode:  oe_n_d = ~MASK_TWO;
        four_lane_mode: oe_n_d = ~MASK_FOUR;
        default:        oe_n_d = ~MASK_SINGLE_IN;
      endcase
    end
    if (mode_d != four_lane_mode) begin
      out_d[3] = !(st_d == h_low && !cs_n_d && pause_req);
      oe_n_d[3] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= h_idle; mode_q <= four_lane_mode; div_q <= CNT_ZERO; cnt_q <= CNT_ZERO;
      sh_q <= 8'h00; rsp_q <= 8'h00; init_q <= 2'h2; read_q <= 1'b0; last_q <= 1'b0;
      first_q <= 1'b1; int_q <= 1'b0; sck_q <= 1'b0; cs_n_q <= 1'b1; ack_q <= 1'b0;
      ready_q <= 1'b0; out_q <= LANES_IDLE; oe_n_q <= LANES_IDLE;
      s1_q <= LANES_IDLE; s2_q <= LANES_IDLE;
    end else if (ce) begin
      st_q <= st_d; mode_q <= mode_d; div_q <= div_d; cnt_q <= cnt_d;
      sh_q <= sh_d; rsp_q <= rsp_d; init_q <= init_d; read_q <= read_d; last_q <= last_d;
      first_q <= first_d; int_q <= int_d; sck_q <= sck_d; cs_n_q <= cs_n_d; ack_q <= ack_d;
      ready_q <= ready_d; out_q <= out_d; oe_n_q <= oe_n_d;
      s1_q <= link.lane; s2_q <= s1_q;
    end
  end

  assign link.cs_n      = cs_n_q;
  assign link.sck       = sck_q;
  assign link.host_out  = out_q;
  assign link.host_oe_n = oe_n_q;
  assign ready          = ready_q;
  assign ack            = ack_q;
  assign rsp_data       = rsp_q;
  assign lane_mode      = mode_q;
endmodule

// file: sram_lane_device.sv
// Purpose: Serial SRAM front end: bit sampling, output edges, pause and lane width.
// Assumes: Chip select, serial clock and lanes are pins, sampled by clk.
// Notes:   The memory behind it is user logic on the rx and tx ports.
`timescale 1ns/1ns

// Operation
// - Pause disabled while in four-lane mode
// - Sample input bits on serial clock rise
// - Change output only after serial clock fall
// - Master holds pause pin high when idle
// - Pause freezes state, keeps partial sequence
// - Pause begun at clock low, else next fall
// - Master keeps select low while paused
// - While paused ignore clock and input
// - Resume at clock low, else next fall
// - Pause pin fall releases output at once
// - Pause pin rise drives output again
// - Two-lane: two bits per clock, MSB first
// - Four-lane: nibble per clock, upper first
// - Enter-two-lane command switches to two lanes
// - Enter-four-lane command switches to four lanes
// - Lane-width reset, current width, back to single
// - Reset master recovers device lane width
// - Enter-two-lane opcode is 0x3B
// - Enter-four-lane opcode is 0x38
// - Lane-width reset opcode is 0xFF
// - Select high aborts and releases output
module sram_lane_device
  import sram_lane_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  input  wire logic                      ce,
  // Link
  sram_lane_if.device                    link,
  // Received bytes
  output logic [7:0]                     rx_data,
  output logic                           rx_valid,
  output logic                           rx_first,
  // Returned bytes
  input  wire logic [7:0]                tx_data,
  input  wire logic                      tx_en,
  // Status
  output sram_lane_pkg::lane_mode_t      lane_mode,
  output logic                           paused,
  output logic                           selected
);
  // Sync vector layout: {lanes[3:0], sck, cs_n}
  localparam logic [5:0] SYNC_RESET = 6'h3D;
  localparam int         CS_BIT     = 0;
  localparam int         SCK_BIT    = 1;
  localparam int         LANE_LO    = 2;

  lane_mode_t  mode_q, mode_d;
  logic [5:0]  s1_q, s2_q, s3_q;
  logic [3:0]  lanes, step;
  logic [3:0]  cnt_q, cnt_d, ocnt_q, ocnt_d, out_q, out_d, oe_n_q, oe_n_d, mask;
  logic [7:0]  rx_sh_q, rx_sh_d, rx_q, rx_d, tx_sh_q, tx_sh_d;
  logic        paused_q, paused_d, first_q, first_d, drive_q, drive_d;
  logic        rxv_q, rxv_d, rxf_q, rxf_d, sel_q, sel_d;
  logic        cs_n, sck, sck_rise, sck_fall, hold_lvl, active;
  logic [7:0]  byte_in;
  logic [3:0]  cnt_next, ocnt_next;

  // Two-stage synchroniser; s3 is only the edge reference
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= SYNC_RESET;
      s2_q <= SYNC_RESET;
      s3_q <= SYNC_RESET;
    end else if (ce) begin
      s1_q <= {link.lane, link.sck, link.cs_n};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_comb begin
    mode_d   = mode_q;
    cnt_d    = cnt_q;
    ocnt_d   = ocnt_q;
    rx_sh_d  = rx_sh_q;
    rx_d     = rx_q;
    tx_sh_d  = tx_sh_q;
    paused_d = paused_q;
    first_d  = first_q;
    drive_d  = drive_q;
    rxv_d    = 1'b0;
    rxf_d    = rxf_q;
    out_d    = out_q;
    cs_n     = s2_q[CS_BIT];
    sck      = s2_q[SCK_BIT];
    sck_rise = s2_q[SCK_BIT] && !s3_q[SCK_BIT];
    sck_fall = !s2_q[SCK_BIT] && s3_q[SCK_BIT];
    lanes    = s2_q[LANE_LO +: 4];
    step     = lane_step(mode_q);
    // Lane 3 is data in four-lane mode, so the pause pin reads as released
    hold_lvl = (mode_q == four_lane_mode) || lanes[3];
    sel_d    = !cs_n;
    byte_in  = shift_in(rx_sh_q, lanes, mode_q);
    cnt_next = cnt_q + step;
    ocnt_next = ocnt_q + step;

    if (cs_n) begin
      // Deselect drops any partial sequence and the pause
      paused_d = 1'b0;
      cnt_d    = CNT_ZERO;
      ocnt_d   = CNT_ZERO;
      first_d  = 1'b1;
      drive_d  = 1'b0;
    end else if (!sck || sck_fall) begin
      // Pause pin change seen with clock high waits for the next fall
      paused_d = !hold_lvl;
    end

    // A paused device counts no edges and takes no bits
    active = !cs_n && !paused_q;

    if (active && sck_rise) begin
      rx_sh_d = byte_in;
      if (cnt_next == BYTE_BITS) begin
        cnt_d   = CNT_ZERO;
        rx_d    = byte_in;
        rxv_d   = 1'b1;
        rxf_d   = first_q;
        first_d = 1'b0;
        if (first_q) begin
          if (byte_in == ENTER_TWO_LANE_CMD) begin
            mode_d = two_lane_mode;
          end else if (byte_in == ENTER_FOUR_LANE_CMD) begin
            mode_d = four_lane_mode;
          end else if (byte_in == LANE_WIDTH_RESET_CMD && mode_q != single_lane_mode) begin
            mode_d = single_lane_mode;
          end
        end
      end else begin
        cnt_d = cnt_next;
      end
    end

    if (active && sck_fall) begin
      if (tx_en) begin
        // New byte at a byte boundary, else move to the next lane group
        tx_sh_d = (ocnt_q == CNT_ZERO) ? tx_data : shift_in(tx_sh_q, CNT_ZERO, mode_q);
        ocnt_d  = (ocnt_next == BYTE_BITS) ? CNT_ZERO : ocnt_next;
        drive_d = 1'b1;
        // Single-lane data leaves on lane 1, the serial output
        out_d = (mode_q == single_lane_mode) ?
                {2'h0, tx_sh_d[7], 1'b0} : lane_top(tx_sh_d, mode_q);
      end else begin
        drive_d = 1'b0;
        ocnt_d  = CNT_ZERO;
      end
    end

    unique case (mode_q)
      two_lane_mode:  mask = MASK_TWO;
      four_lane_mode: mask = MASK_FOUR;
      default:        mask = MASK_SINGLE_SO;
    endcase
    // Enable follows the pause pin level directly, not the clock-gated pause
    oe_n_d = ~(mask & {4{drive_d && hold_lvl && !cs_n}});
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q   <= single_lane_mode;
      cnt_q    <= CNT_ZERO;
      ocnt_q   <= CNT_ZERO;
      rx_sh_q  <= 8'h00;
      rx_q     <= 8'h00;
      tx_sh_q  <= 8'h00;
      paused_q <= 1'b0;
      first_q  <= 1'b1;
      drive_q  <= 1'b0;
      rxv_q    <= 1'b0;
      rxf_q    <= 1'b0;
      sel_q    <= 1'b0;
      out_q    <= CNT_ZERO;
      oe_n_q   <= LANES_IDLE;
    end else if (ce) begin
      mode_q   <= mode_d;
      cnt_q    <= cnt_d;
      ocnt_q   <= ocnt_d;
      rx_sh_q  <= rx_sh_d;
      rx_q     <= rx_d;
      tx_sh_q  <= tx_sh_d;
      paused_q <= paused_d;
      first_q  <= first_d;
      drive_q  <= drive_d;
      rxv_q    <= rxv_d;
      rxf_q    <= rxf_d;
      sel_q    <= sel_d;
      out_q    <= out_d;
      oe_n_q   <= oe_n_d;
    end
  end

  assign link.dev_out  = out_q;
  assign link.dev_oe_n = oe_n_q;
  assign rx_data       = rx_q;
  assign rx_valid      = rxv_q;
  assign rx_first      = rxf_q;
  assign lane_mode     = mode_q;
  assign paused        = paused_q;
  assign selected      = sel_q;
endmodule

// file: sram_lane_checker.sv
// Purpose: Link-level assertions between the host and device ends.
// Assumes: Pins sampled on clk; the device sees pins about three cycles late.
// Notes:   Lane 3 falling while the host drives it and lane 2 is free marks a pause.
`timescale 1ns/1ns
module sram_lane_checker (
  // Clock and reset
  input wire logic       clk,
  input wire logic       arst_n,
  // Link
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic [3:0] host_out,
  input wire logic [3:0] host_oe_n,
  input wire logic [3:0] dev_out,
  input wire logic [3:0] dev_oe_n,
  input wire logic [3:0] lane
);
  logic       sck_q, sck_d;
  logic [2:0] fall_q, fall_d;
  logic [3:0] oe_q, oe_d;
  logic       pause_start;

  assign pause_start = !cs_n && !host_oe_n[3] && host_oe_n[2];

  // Cycles since the last serial clock fall, saturating
  always_comb begin
    sck_d  = sck;
    fall_d = (sck_q && !sck) ? 3'h1 : ((fall_q == 3'h7) ? fall_q : fall_q + 3'h1);
    oe_d   = cs_n ? 4'hF : ((lane[3] && dev_oe_n != 4'hF) ? dev_oe_n : oe_q);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_q  <= 1'b0;
      fall_q <= 3'h7;
      oe_q   <= 4'hF;
    end else begin
      sck_q  <= sck_d;
      fall_q <= fall_d;
      oe_q   <= oe_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  deselect_release_a: assert property (cs_n [*5] |-> dev_oe_n == 4'hF)
    else $error("device drives a lane while deselected");
  out_after_fall_a: assert property (!cs_n && $changed(dev_out) |-> fall_q inside {[3'h1:3'h6]})
    else $error("device output changed away from a clock fall");
  lane_clash_a: assert property ((~host_oe_n & ~dev_oe_n) == 4'h0)
    else $error("host and device drive one lane");
  pause_release_a: assert property ($fell(lane[3]) && pause_start |-> ##[1:5] dev_oe_n == 4'hF)
    else $error("output not released after pause");
  resume_drive_a: assert property ($rose(lane[3]) && pause_start && oe_q != 4'hF
                                   |-> ##[1:5] dev_oe_n == oe_q)
    else $error("output not driven again after pause");
  idle_pause_high_a: assert property (cs_n [*5] |-> lane[3])
    else $error("pause pin low while idle");
  host_setup_a: assert property (!cs_n && $changed(host_out & ~host_oe_n) |-> !sck)
    else $error("host changed a lane while clock high");
  pause_hold_sel_a: assert property ($fell(lane[3]) && pause_start |-> !cs_n [*8])
    else $error("select dropped during pause");

  cover property ($fell(lane[3]) && pause_start);
  cover property (!cs_n && dev_oe_n == 4'h0);
  cover property (!cs_n && dev_oe_n == 4'hC);
endmodule

// file: test_serial_sram_io_lane_and_pause_control.sv
// Purpose: Host and device ends joined; writes, reads, pause and lane modes.
// Assumes: 10 MHz clock; host recovers single-lane mode by itself after reset.
// Notes:   Frames are spaced so the device sees deselect before the next one.
`timescale 1ns/1ns
module test_serial_sram_io_lane_and_pause_control;
  import sram_lane_pkg::*;
  logic       clk = 1'b0;
  logic       arst_n;
  logic       host_arst_n;
  logic       req;
  logic [7:0] req_data;
  logic       req_read;
  logic       req_last;
  logic       pause_req;
  logic       ready;
  logic       ack;
  logic [7:0] rsp_data;
  lane_mode_t host_mode;
  logic [7:0] rx_data;
  logic       rx_valid;
  logic       rx_first;
  logic [7:0] tx_data;
  logic       tx_en;
  lane_mode_t dev_mode;
  logic       paused;
  logic       selected;
  int         n_errors = 0;
  int         n_tests = 0;
  int         n_rx = 0;
  int         n_sent = 0;

  always #50 clk = ~clk;

  always @(posedge clk) begin
    if (rx_valid === 1'b1)
      n_rx <= n_rx + 1;
  end

  sram_lane_if sram_lane_if_inst ();

  sram_lane_host sram_lane_host_inst (.clk(clk), .arst_n(host_arst_n), .ce(1'b1),
    .link(sram_lane_if_inst), .req(req), .req_data(req_data), .req_read(req_read),
    .req_last(req_last), .pause_req(pause_req), .ready(ready), .ack(ack),
    .rsp_data(rsp_data), .lane_mode(host_mode));

  sram_lane_device sram_lane_device_inst (.clk(clk), .arst_n(arst_n), .ce(1'b1),
    .link(sram_lane_if_inst), .rx_data(rx_data), .rx_valid(rx_valid), .rx_first(rx_first),
    .tx_data(tx_data), .tx_en(tx_en), .lane_mode(dev_mode), .paused(paused),
    .selected(selected));

  sram_lane_checker sram_lane_checker_inst (.clk(clk), .arst_n(arst_n),
    .cs_n(sram_lane_if_inst.cs_n), .sck(sram_lane_if_inst.sck),
    .host_out(sram_lane_if_inst.host_out), .host_oe_n(sram_lane_if_inst.host_oe_n),
    .dev_out(sram_lane_if_inst.dev_out), .dev_oe_n(sram_lane_if_inst.dev_oe_n),
    .lane(sram_lane_if_inst.lane));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task test_done();
    if (n_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // One byte through the host port; a hang shows up as a failed compare
  task automatic xfer(input logic [7:0] d, input logic rd, input logic last,
                      output logic [7:0] q);
    int i;
    for (i = 0; i < 2000 && ready !== 1'b1; i++)
      @(negedge clk);
    check({7'h0, ready}, 8'h01);
    @(posedge clk);
    req      <= 1'b1;
    req_data <= d;
    req_read <= rd;
    req_last <= last;
    @(posedge clk);
    req <= 1'b0;
    for (i = 0; i < 2000 && ack !== 1'b1; i++)
      @(negedge clk);
    check({7'h0, ack}, 8'h01);
    q = rsp_data;
    n_sent++;
  endtask

  task automatic wr(input logic [7:0] d, input logic first, input logic last);
    logic [7:0] q;
    xfer(d, 1'b0, last, q);
    check(q, d);
    check(rx_data, d);
    check({7'h0, rx_first}, {7'h0, first});
    check({7'h0, selected}, 8'h01);
    if (last) begin
      repeat (12) @(posedge clk);
      check({7'h0, selected}, 8'h00);
    end
  endtask

  task automatic pause_try(input logic expect_pause);
    repeat (expect_pause ? 40 : 6) @(posedge clk);
    pause_req <= 1'b1;
    repeat (40) @(negedge clk);
    check({7'h0, paused}, {7'h0, expect_pause});
    if (expect_pause)
      check({4'h0, sram_lane_if_inst.dev_oe_n}, 8'h0F);
    @(posedge clk);
    pause_req <= 1'b0;
  endtask

  // Last byte of a frame read back; tx_en dropped before the closing fall is seen
  task automatic rd(input logic [7:0] v, input logic hold, input logic expect_pause);
    logic [7:0] q;
    @(posedge clk);
    tx_data <= v;
    tx_en   <= 1'b1;
    fork
      begin
        xfer(8'h00, 1'b1, 1'b1, q);
        @(posedge clk);
        tx_en <= 1'b0;
      end
      if (hold)
        pause_try(expect_pause);
    join
    check(q, v);
    repeat (16) @(posedge clk);
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    test_done();
  end

  initial begin
    lane_mode_t m;
    logic [7:0] cmd;
    arst_n    = 1'b0;
    host_arst_n = 1'b0;
    req       = 1'b0;
    req_data  = 8'h00;
    req_read  = 1'b0;
    req_last  = 1'b0;
    pause_req = 1'b0;
    tx_data   = 8'h00;
    tx_en     = 1'b0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    host_arst_n <= 1'b1;
    for (int i = 0; i < 2000 && ready !== 1'b1; i++)
      @(negedge clk);
    check({6'h0, dev_mode}, {6'h0, single_lane_mode});
    check({6'h0, host_mode}, {6'h0, single_lane_mode});
    check({7'h0, paused}, 8'h00);
    wr(8'h02, 1'b1, 1'b0);
    wr(8'hA5, 1'b0, 1'b1);
    wr(LANE_WIDTH_RESET_CMD, 1'b1, 1'b1);
    check({6'h0, dev_mode}, {6'h0, single_lane_mode});
    wr(8'h03, 1'b1, 1'b0);
    rd(8'h96, 1'b1, 1'b1);
    for (int k = 0; k < 2; k++) begin
      m   = k ? four_lane_mode : two_lane_mode;
      cmd = k ? ENTER_FOUR_LANE_CMD : ENTER_TWO_LANE_CMD;
      wr(cmd, 1'b1, 1'b1);
      check({6'h0, dev_mode}, {6'h0, m});
      check({6'h0, host_mode}, {6'h0, m});
      wr(8'h02, 1'b1, 1'b0);
      wr(8'h5A, 1'b0, 1'b0);
      wr(8'hC3, 1'b0, 1'b1);
      wr(8'h03, 1'b1, 1'b0);
      rd(8'h69, k[0], 1'b0);
      wr(LANE_WIDTH_RESET_CMD, 1'b1, 1'b1);
      check({6'h0, dev_mode}, {6'h0, single_lane_mode});
      check({6'h0, host_mode}, {6'h0, single_lane_mode});
    end
    // Host alone reset while the device sits in four-lane mode
    wr(ENTER_FOUR_LANE_CMD, 1'b1, 1'b1);
    host_arst_n <= 1'b0;
    repeat (4) @(posedge clk);
    host_arst_n <= 1'b1;
    for (int i = 0; i < 2000 && ready !== 1'b1; i++)
      @(negedge clk);
    // The first recovery frame lands as one whole byte in four-lane mode
    n_sent++;
    check({7'h0, ready}, 8'h01);
    check({6'h0, dev_mode}, {6'h0, single_lane_mode});
    check({6'h0, host_mode}, {6'h0, single_lane_mode});
    check(n_rx[7:0], n_sent[7:0]);
    test_done();
  end
endmodule
